// ==== verilog/stream_pkg.sv ====
// Constants shared by the continuous reading streamer and its testbench
package stream_pkg;
   localparam int          CLK_HZ_DEF      = 100_000_000;
   localparam int          CONV_PERIOD_MS  = 125;
   localparam int          CONV_CYCLES_DEF = CONV_PERIOD_MS * (CLK_HZ_DEF / 1000);
   localparam int          CAL_PAUSE_MS    = 20;
   localparam int          CAL_CYCLES_DEF  = CAL_PAUSE_MS * (CLK_HZ_DEF / 1000);
   localparam int          CONV_PER_CAL    = 15;
   localparam int          FIFO_DEPTH_DEF  = 8;
   localparam int          UART_BITS       = 10;
   // Register map, byte addresses
   localparam logic [7:0]  SETUP_ADDR      = 8'h00;
   localparam logic [7:0]  STATUS_ADDR     = 8'h04;
   // Setup fields
   localparam int          SET_RATE_LSB    = 0;
   localparam int          SET_LF_BIT      = 4;
   localparam int          SET_CIN_BIT     = 5;
   localparam int          SET_ADDR_LSB    = 8;
   localparam logic [13:0] SETUP_RST       = 14'h0105;
   localparam logic [5:0]  DEFAULT_ADDR    = 6'h01;
   // Status fields
   localparam int          ST_STREAM_BIT   = 0;
   localparam int          ST_CAL_BIT      = 1;
   localparam int          ST_BUSY_BIT     = 2;
   localparam int          ST_CONV_LSB     = 4;
   localparam int          ST_MSGS_LSB     = 8;
   // Message characters
   localparam logic [7:0]  CH_STAR         = 8'h2a;
   localparam logic [7:0]  CH_PLUS         = 8'h2b;
   localparam logic [7:0]  CH_MINUS        = 8'h2d;
   localparam logic [7:0]  CH_DOT          = 8'h2e;
   localparam logic [7:0]  CH_CR           = 8'h0d;
   localparam logic [7:0]  CH_LF           = 8'h0a;
   localparam logic [7:0]  CH_ZERO         = 8'h30;
   localparam logic [3:0]  IDX_CR          = 4'ha;
   localparam logic [3:0]  IDX_LF          = 4'hb;

   // Bit period in clocks for each rate code: 300 * 2**code baud, codes above 7 held at 300 * 2**7
   function automatic logic [31:0] baud_div(input logic [3:0] code, input int clk_hz);
      int baud;
      baud = 300 << ((code > 4'h7) ? 4'h7 : code);
      return 32'(clk_hz / baud);
   endfunction
endpackage

// ==== verilog/byte_fifo.sv ====
// Parameterised valid/ready FIFO held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             i_mclk,
   input  wire logic             i_nrst,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [AW:0]      cnt_r;
   logic             push;
   logic             pop;

   assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data  = mem_r[rd_r];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem_r[wr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// ==== verilog/continuous_reading_streamer.sv ====
// Continuous reading streamer: conversion pacing, message former, serial transmitter
//
// Overview of operation
// [RULE1] One new reading sent per finished conversion, about every 125 ms, unasked.
// [RULE2] At slow bit rates a message starts only after the previous fully left.
// [RULE3] After every fifteenth conversion an auto-calibration pause delays the stream.
// [RULE4] An unused receive line must be grounded by the installer, not left open.
// [RULE5] Default-select low forces communication address one, ignoring stored setup.
// [RULE6] Installer leaves default-select open for continuous operation.
// [RULE7] Streaming only with mode select low; accept stream only with second input low.
// [RULE8] Stream acceptance also needs the continuous-input enable bit in setup.
// [RULE9] Bit rate is the one setup field to change; both ends must match.
// [RULE10] Each reading: asterisk, signed fixed-point value, carriage return, optional LF.
// [RULE11] Commands are ignored while mode select is held low.
// [RULE12] Mode select is sampled only between messages, never truncating one.
// [RULE13] A new stored bit rate reaches the transmitter only after the next reset.
`timescale 1ns/1ps
`default_nettype none
module continuous_reading_streamer #(
   parameter int CLK_HZ      = stream_pkg::CLK_HZ_DEF,
   parameter int CONV_CYCLES = stream_pkg::CONV_CYCLES_DEF,
   parameter int CAL_CYCLES  = stream_pkg::CAL_CYCLES_DEF,
   parameter int FIFO_DEPTH  = stream_pkg::FIFO_DEPTH_DEF
) (
   input  wire logic        i_mclk,
   input  wire logic        i_nrst,
   input  wire logic        i_npor,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic        i_stream_mode_select_n,
   input  wire logic        i_default_select_n,
   input  wire logic        i_second_digital_input,
   input  wire logic        i_reading_neg,
   input  wire logic [27:0] i_reading_bcd,
   output logic             o_txd,
   output logic             o_cmd_enable,
   output logic      [5:0]  o_comm_addr,
   output logic             o_stream_accept,
   output logic             o_streaming,
   output logic             o_calibrating
);
   import stream_pkg::*;
   typedef enum logic [1:0] {M_IDLE = 2'b00, M_SEND = 2'b01, M_DRAIN = 2'b11} msg_type;
   typedef enum logic [1:0] {T_IDLE = 2'b00, T_SHIFT = 2'b01} tx_type;
   logic [13:0] setup_r;
   logic [3:0]  active_rate_r;
   logic        loaded_r;
   logic [31:0] bit_div_r;
   logic [31:0] conv_cnt_r;
   logic [31:0] cal_cnt_r;
   logic [3:0]  conv_idx_r;
   logic        cal_r;
   logic        conv_done;
   logic        pending_r;
   logic        neg_r;
   logic [27:0] bcd_r;
   logic        stream_r;
   msg_type     msg_r;
   logic [3:0]  idx_r;
   logic [7:0]  msg_byte;
   logic [7:0]  msgs_r;
   logic        msg_start;
   logic        push_valid;
   logic        push_ready;
   logic        pop_valid;
   logic [7:0]  pop_data;
   logic        pop_ready;
   tx_type      tx_r;
   logic [9:0]  shift_r;
   logic [3:0]  bit_cnt_r;
   logic [31:0] baud_cnt_r;
   logic        bus_req;
   logic [31:0] rd_word;
   // Wishbone slave, one wait state, unmapped reads return zero
   assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   always_comb begin
      rd_word = 32'h0000_0000;
      case (i_wb_adr)
         SETUP_ADDR:  rd_word = {18'h00000, setup_r};
         STATUS_ADDR: rd_word = {16'h0000, msgs_r, conv_idx_r, 1'b0,
                                 (tx_r != T_IDLE), cal_r, stream_r};
         default:     rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= bus_req;
         o_wb_dat <= bus_req ? rd_word : 32'h0000_0000;
      end
   end

   // Setup survives i_nrst; only power-up restores defaults
   always_ff @(posedge i_mclk or negedge i_npor) begin
      if (!i_npor) begin
         setup_r <= SETUP_RST;
      end else if (bus_req && i_wb_we && i_wb_adr == SETUP_ADDR) begin
         if (i_wb_sel[0]) begin
            setup_r[7:0] <= i_wb_dat[7:0];
         end
         if (i_wb_sel[1]) begin
            setup_r[13:8] <= i_wb_dat[13:8];
         end
      end
   end

   // Rate is caught once after reset release so a download never glitches a frame
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         loaded_r      <= 1'b0;
         active_rate_r <= 4'h0;
         bit_div_r     <= 32'h0000_0001;
      end else if (!loaded_r) begin
         loaded_r      <= 1'b1; // [RULE13]
         active_rate_r <= setup_r[SET_RATE_LSB +: 4];
         bit_div_r     <= baud_div(setup_r[SET_RATE_LSB +: 4], CLK_HZ); // [RULE9]
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_comm_addr     <= DEFAULT_ADDR;
         o_cmd_enable    <= 1'b0;
         o_stream_accept <= 1'b0;
         o_streaming     <= 1'b0;
         o_calibrating   <= 1'b0;
      end else begin
         o_comm_addr     <= !i_default_select_n ? DEFAULT_ADDR
                                                : setup_r[SET_ADDR_LSB +: 6]; // [RULE5]
         o_cmd_enable    <= !stream_r; // [RULE11]
         o_stream_accept <= !i_second_digital_input && setup_r[SET_CIN_BIT]; // [RULE7] [RULE8]
         o_streaming     <= stream_r;
         o_calibrating   <= cal_r;
      end
   end

   // Conversion pacing with a calibration pause after every fifteenth
   assign conv_done = !cal_r && (conv_cnt_r == 32'(CONV_CYCLES - 1));
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         conv_cnt_r <= 32'h0000_0000;
         cal_cnt_r  <= 32'h0000_0000;
         conv_idx_r <= 4'h0;
         cal_r      <= 1'b0;
      end else if (cal_r) begin
         cal_cnt_r <= cal_cnt_r + 32'h0000_0001;
         if (cal_cnt_r == 32'(CAL_CYCLES - 1)) begin
            cal_r     <= 1'b0;
            cal_cnt_r <= 32'h0000_0000;
         end
      end else begin
         conv_cnt_r <= conv_done ? 32'h0000_0000 : conv_cnt_r + 32'h0000_0001;
         if (conv_done) begin
            if (conv_idx_r == 4'(CONV_PER_CAL - 1)) begin
               conv_idx_r <= 4'h0;
               cal_r      <= 1'b1; // [RULE3]
            end else begin
               conv_idx_r <= conv_idx_r + 4'h1;
            end
         end
      end
   end

   // Latest reading; a reading that lands while a message is out is replaced, not queued
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         pending_r <= 1'b0;
         neg_r     <= 1'b0;
         bcd_r     <= 28'h0000000;
      end else begin
         if (conv_done) begin
            pending_r <= 1'b1; // [RULE1]
            neg_r     <= i_reading_neg;
            bcd_r     <= i_reading_bcd;
         end else if (msg_start) begin
            pending_r <= 1'b0;
         end
      end
   end

   // Next message waits for buffer and transmitter to empty
   assign msg_start = (msg_r == M_IDLE) && stream_r && pending_r
                      && !pop_valid && (tx_r == T_IDLE); // [RULE2]

   always_comb begin
      msg_byte = CH_CR;
      case (idx_r)
         4'h0:    msg_byte = CH_STAR; // [RULE10]
         4'h1:    msg_byte = neg_r ? CH_MINUS : CH_PLUS;
         4'h2:    msg_byte = CH_ZERO | {4'h0, bcd_r[27:24]};
         4'h3:    msg_byte = CH_ZERO | {4'h0, bcd_r[23:20]};
         4'h4:    msg_byte = CH_ZERO | {4'h0, bcd_r[19:16]};
         4'h5:    msg_byte = CH_ZERO | {4'h0, bcd_r[15:12]};
         4'h6:    msg_byte = CH_ZERO | {4'h0, bcd_r[11:8]};
         4'h7:    msg_byte = CH_DOT;
         4'h8:    msg_byte = CH_ZERO | {4'h0, bcd_r[7:4]};
         4'h9:    msg_byte = CH_ZERO | {4'h0, bcd_r[3:0]};
         IDX_LF:  msg_byte = CH_LF;
         default: msg_byte = CH_CR;
      endcase
   end

   assign push_valid = (msg_r == M_SEND);

   // Mode select only follows the pin between messages
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         stream_r <= 1'b0;
      end else if (msg_r == M_IDLE && !msg_start) begin
         stream_r <= !i_stream_mode_select_n; // [RULE7] [RULE12]
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         msg_r  <= M_IDLE;
         idx_r  <= 4'h0;
         msgs_r <= 8'h00;
      end else begin
         case (msg_r)
            M_IDLE: begin
               idx_r <= 4'h0;
               if (msg_start) begin
                  msg_r <= M_SEND;
               end
            end
            M_SEND: begin
               if (push_ready) begin
                  if ((idx_r == IDX_CR && !setup_r[SET_LF_BIT]) || idx_r == IDX_LF) begin
                     msg_r  <= M_DRAIN;
                     msgs_r <= msgs_r + 8'h01;
                  end else begin
                     idx_r <= idx_r + 4'h1;
                  end
               end
            end
            M_DRAIN: begin
               if (!pop_valid && tx_r == T_IDLE) begin
                  msg_r <= M_IDLE;
               end
            end
            default: msg_r <= M_IDLE;
         endcase
      end
   end

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_mclk      (i_mclk),
      .i_nrst      (i_nrst),
      .i_in_valid  (push_valid),
      .o_in_ready  (push_ready),
      .i_in_data   (msg_byte),
      .o_out_valid (pop_valid),
      .i_out_ready (pop_ready),
      .o_out_data  (pop_data)
   );

   // 8N1 transmitter; the buffer stalls the former whenever the line is slower
   assign pop_ready = (tx_r == T_IDLE);
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         tx_r       <= T_IDLE;
         shift_r    <= 10'h3ff;
         bit_cnt_r  <= 4'h0;
         baud_cnt_r <= 32'h0000_0000;
         o_txd      <= 1'b1;
      end else begin
         case (tx_r)
            T_IDLE: begin
               o_txd <= 1'b1;
               if (pop_valid) begin
                  shift_r    <= {1'b1, pop_data, 1'b0};
                  bit_cnt_r  <= 4'h0;
                  baud_cnt_r <= 32'h0000_0000;
                  tx_r       <= T_SHIFT;
               end
            end
            T_SHIFT: begin
               o_txd <= shift_r[0];
               if (baud_cnt_r == bit_div_r - 32'h0000_0001) begin
                  baud_cnt_r <= 32'h0000_0000;
                  shift_r    <= {1'b1, shift_r[9:1]};
                  if (bit_cnt_r == 4'(UART_BITS - 1)) begin
                     tx_r <= T_IDLE;
                  end else begin
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end else begin
                  baud_cnt_r <= baud_cnt_r + 32'h0000_0001;
               end
            end
            default: tx_r <= T_IDLE;
         endcase
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   a_ack_single:    assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held two cycles");
   a_ack_timing:    assert property (bus_req |=> o_wb_ack)
      else $error("bus not answered in one cycle");
   a_start_reading: assert property (conv_done && !i_stream_mode_select_n // [RULE1]
      && msg_r == M_IDLE |=> ##1 msg_r == M_SEND)
      else $error("conversion did not start a message");
   a_start_idle:    assert property (msg_r == M_IDLE |-> tx_r == T_IDLE && !pop_valid) // [RULE2]
      else $error("idle while previous message still sending");
   a_cal_entry:     assert property (conv_done && conv_idx_r == 4'he // [RULE3]
      |=> cal_r ##1 !conv_done)
      else $error("no calibration after fifteenth conversion");
   a_default_addr:  assert property (!i_default_select_n |=> o_comm_addr == 6'h01) // [RULE5]
      else $error("default address not forced");
   a_accept_gate:   assert property (o_stream_accept |-> $past(setup_r[SET_CIN_BIT])) // [RULE8]
      else $error("stream accepted with enable bit clear");
   a_msg_star:      assert property (msg_start |=> push_valid && msg_byte == CH_STAR) // [RULE10]
      else $error("message does not open with asterisk");
   a_cmd_blocked:   assert property (stream_r |=> !o_cmd_enable) // [RULE11]
      else $error("commands enabled while streaming");
   a_mode_stable:   assert property (msg_r != M_IDLE |=> $stable(stream_r)) // [RULE12]
      else $error("mode changed inside a message");
   a_rate_fixed:    assert property (loaded_r |=> $stable(active_rate_r)) // [RULE13]
      else $error("bit rate changed without reset");
   c_message:  cover property (msg_start ##1 msg_r == M_SEND);
   c_cal:      cover property ($rose(cal_r));
   c_wr_setup: cover property (bus_req && i_wb_we && i_wb_adr == SETUP_ADDR);
   c_lf:       cover property (push_valid && push_ready && idx_r == IDX_LF);
endmodule
`default_nettype wire

// ==== testbench/reading_listener.sv ====
// Serial listener standing in for the host or output module on the stream
`timescale 1ns/1ps
`default_nettype none
module reading_listener (
   input  wire logic        i_mclk,
   input  wire logic        i_nrst,
   input  wire logic        i_rxd,
   input  wire logic [15:0] i_bit_clks,
   output logic             o_byte_valid,
   output logic      [7:0]  o_byte,
   output logic             o_frame_err
);
   logic        busy_r;
   logic [3:0]  idx_r;
   logic [15:0] cnt_r;

   // Listens only and drives nothing back: the device receive side stays grounded
   // Mid-bit sampling at the agreed rate, 8N1, LSB first; a bad stop bit stays flagged
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         busy_r       <= 1'b0;
         idx_r        <= 4'h0;
         cnt_r        <= 16'h0;
         o_byte_valid <= 1'b0;
         o_byte       <= 8'h00;
         o_frame_err  <= 1'b0;
      end else begin
         o_byte_valid <= 1'b0;
         if (!busy_r && !i_rxd) begin
            busy_r <= 1'b1;
            idx_r  <= 4'h0;
            cnt_r  <= i_bit_clks >> 1;
         end else if (busy_r && cnt_r != 16'h0) begin
            cnt_r <= cnt_r - 16'h1;
         end else if (busy_r) begin
            cnt_r <= i_bit_clks - 16'h1;
            idx_r <= idx_r + 4'h1;
            if (idx_r == 4'h0 && i_rxd) begin
               busy_r      <= 1'b0;
               o_frame_err <= 1'b1;
            end else if (idx_r == 4'h9) begin
               busy_r       <= 1'b0;
               o_byte_valid <= 1'b1;
               o_frame_err  <= o_frame_err | ~i_rxd;
            end else if (idx_r != 4'h0) begin
               o_byte <= {i_rxd, o_byte[7:1]};
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/test_continuous_reading_streamer.sv ====
// Self-checking bench for the continuous reading streamer
`timescale 1ns/1ps
`default_nettype none
module test_continuous_reading_streamer;
   import stream_pkg::*;
   // Shrunk clock so 9600 baud is 40 clocks a bit and 38400 is 10
   localparam int CLK  = 384000;
   localparam int CONV = 1500;
   localparam int CAL  = 100;
   logic        mclk, nrst, npor, cyc, stb, we, mode_n, dflt_n, di2, neg;
   logic        ack, txd, cmd_en, accept, streaming, cal, bvalid, ferr;
   logic [7:0]  adr, rbyte;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, rd;
   logic [27:0] bcd;
   logic [5:0]  caddr;
   logic [15:0] bit_clks;
   int          err_count = 0;
   int          compares = 0;
   int          seed, n0;
   longint      cycle = 0;
   longint      cal_len = 0;
   longint      nbytes = 0;
   longint      t[0:16];

   continuous_reading_streamer #(.CLK_HZ(CLK), .CONV_CYCLES(CONV), .CAL_CYCLES(CAL),
      .FIFO_DEPTH(FIFO_DEPTH_DEF)) continuous_reading_streamer_i (
      .i_mclk(mclk), .i_nrst(nrst), .i_npor(npor), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_stream_mode_select_n(mode_n), .i_default_select_n(dflt_n),
      .i_second_digital_input(di2), .i_reading_neg(neg), .i_reading_bcd(bcd),
      .o_txd(txd), .o_cmd_enable(cmd_en), .o_comm_addr(caddr),
      .o_stream_accept(accept), .o_streaming(streaming), .o_calibrating(cal));
   reading_listener reading_listener_i (.i_mclk(mclk), .i_nrst(npor), .i_rxd(txd),
      .i_bit_clks(bit_clks), .o_byte_valid(bvalid), .o_byte(rbyte), .o_frame_err(ferr));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycle <= cycle + 1;
      if (cal === 1'b1) cal_len <= cal_len + 1;
      if (bvalid === 1'b1) nbytes <= nbytes + 1;
   end

   function automatic logic [27:0] rnd_bcd();
      logic [27:0] v;
      for (int k = 0; k < 7; k++) v[4*k +: 4] = 4'($unsigned($random(seed)) % 10);
      return v;
   endfunction
   // Character i of the short-form message for a given reading
   function automatic logic [7:0] exp_char(input int i, input logic n, input logic [27:0] v);
      if (i == 0) return CH_STAR;
      if (i == 1) return n ? CH_MINUS : CH_PLUS;
      if (i == 7) return CH_DOT;
      if (i == 10) return CH_CR;
      return CH_ZERO + {4'h0, v[27 - 4 * (i < 7 ? i - 2 : i - 3) -: 4]};
   endfunction

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic check_range(input string name, input longint lo, input longint hi,
                              input longint got);
      compares++;
      if (got < lo || got > hi) begin
         err_count++;
         $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Classic cycle: request held until ack is seen, released at that edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      int n;
      @(posedge mclk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= d;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 100);
      check("bus ack", 32'h1, {31'h0, ack});
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic get_byte(output logic [7:0] b);
      int n;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (bvalid !== 1'b1 && n < 20000);
      if (n >= 20000) begin
         err_count++;
         $display("[ERR] serial byte expected arrival seen none");
      end
      b = rbyte;
   endtask
   // Receives one whole message; quit drops the mode select after its first byte
   task automatic get_msg(output longint ts, input logic quit);
      logic [7:0] b;
      for (int i = 0; i < 11; i++) begin
         get_byte(b);
         if (i == 0) ts = cycle;
         if (i == 0 && quit) begin
            @(posedge mclk);
            mode_n <= 1'b1;
         end
         check("message byte", {24'h0, exp_char(i, neg, bcd)}, {24'h0, b});
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #1_000_000;
      err_count++;
      $display("[ERR] watchdog expected finish seen hang");
      results();
   end

   initial begin
      seed = 32'hefce0810;
      {nrst, npor, cyc, stb, we} = 5'h00;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      {mode_n, dflt_n, di2} = 3'b110;
      bit_clks = 16'd40;
      neg = 1'($random(seed));
      bcd = rnd_bcd();
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      npor <= 1'b1;
      settle(3);
      check("cmd enable", 32'h1, {31'h0, cmd_en});
      check("comm addr", 32'h1, {26'h0, caddr});
      check("accept no enable", 32'h0, {31'h0, accept});
      // Stored rate code 7 must not reach the transmitter before the next reset
      wb(1'b1, SETUP_ADDR, 4'h3, 32'h0000_2a27);
      wb(1'b0, SETUP_ADDR, 4'hf, 32'h0);
      check("setup readback", 32'h0000_2a27, rd);
      wb(1'b1, 8'h10, 4'hf, 32'hffff_ffff);
      wb(1'b0, 8'h10, 4'hf, 32'h0);
      check("unmapped read", 32'h0, rd);
      settle(2);
      check("stored addr", 32'h2a, {26'h0, caddr});
      check("accept on", 32'h1, {31'h0, accept});
      @(posedge mclk);
      dflt_n <= 1'b0;
      di2    <= 1'b1;
      settle(3);
      check("forced addr", 32'h1, {26'h0, caddr});
      check("accept input high", 32'h0, {31'h0, accept});
      @(posedge mclk);
      dflt_n <= 1'b1;
      mode_n <= 1'b0;
      settle(3);
      check("streaming", 32'h1, {31'h0, streaming});
      check("cmd gated", 32'h0, {31'h0, cmd_en});
      get_msg(t[0], 1'b0);
      get_msg(t[1], 1'b0);
      check_range("slow spacing", 440 * 10, 440 * 10 + CONV + 10, t[1] - t[0]);
      @(posedge mclk);
      nrst     <= 1'b0;
      bit_clks <= 16'd10;
      neg      <= ~neg;
      bcd      <= rnd_bcd();
      @(posedge mclk);
      nrst <= 1'b1;
      for (int m = 0; m < 16; m++) get_msg(t[m], 1'b0);
      check_range("conversion spacing", CONV, CONV, t[2] - t[1]);
      check_range("late spacing", CONV, CONV, t[14] - t[13]);
      check_range("calibration gap", CONV + CAL - 2, CONV + CAL + 2, t[15] - t[14]);
      check_range("calibration length", CAL - 1, CAL + 1, cal_len);
      wb(1'b0, STATUS_ADDR, 4'hf, 32'h0);
      check("status streaming", 32'h1, {31'h0, rd[ST_STREAM_BIT]});
      get_msg(t[16], 1'b1);
      // Mode only drops once the last stop bit has left and the former is idle
      settle(30);
      check("streaming off", 32'h0, {31'h0, streaming});
      check("cmd enable back", 32'h1, {31'h0, cmd_en});
      n0 = int'(nbytes);
      settle(2 * CONV);
      check("quiet line", 32'(n0), 32'(nbytes));
      check("frame errors", 32'h0, {31'h0, ferr});
      results();
   end
endmodule
`default_nettype wire
